// ==== hdl/tsa_pkg.sv ====
// Purpose: Shared constants and types of the temperature alert core
// Assumes: Core clock of 100 MHz
// Notes:   Link byte record is filled by the bus framer outside
package tsa_pkg;

   // -------------------------------------------------
   // Timing
   // -------------------------------------------------
   localparam int CLK_NS    = 10;
   localparam int CONV_NS   = 6400000;  // One active conversion
   localparam int CONV_CYC  = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int PER_SHIFT = 4;        // Period = conversion << (sel + 4)

   // -------------------------------------------------
   // Reset values and seeds
   // -------------------------------------------------
   localparam logic       MODE_RST = 1'b0;   // Continuous after reset
   localparam logic [7:0] CRC_SEED = 8'hff;
   localparam logic [7:0] CRC_POLY = 8'h07;  // Shared by checker and generator

   // -------------------------------------------------
   // Types
   // -------------------------------------------------
   typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA, K_CRC} tsa_kind_t;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STBY} tsa_st_t;

   typedef struct packed {
      logic       vld;
      tsa_kind_t  kind;
      logic       rd;    // Byte sent by the device
      logic [7:0] data;
   } tsa_lbyte_t;

   typedef struct packed {
      logic [15:0] hi_lim;
      logic [15:0] lo_lim;
      logic [15:0] hi_hyst;
      logic [15:0] lo_hyst;
      logic [15:0] slew_lim;
   } tsa_lim_t;

   typedef struct packed {
      logic hi_live;
      logic hi_flag;
      logic lo_live;
      logic lo_flag;
      logic slew_live;
      logic slew_flag;
      logic crc_flag;
      logic rdy_flag;
   } tsa_alert_t;

   typedef struct packed {
      tsa_st_t     st;
      logic        mode_shut;
      logic        os_bit;
      logic        os_run;
      logic [31:0] cnt;
      logic [31:0] per;
      logic [2:0]  nsmp;
      logic [18:0] acc;
      logic [15:0] res;
      logic [15:0] prev;
      logic        prev_ok;
      tsa_alert_t  al;
      logic [2:0]  tg;
      logic        tg_seen;
   } tsa_core_t;

   typedef struct packed {
      logic [2:0] rs;
      logic       lrst;
      logic [2:0] es;
      logic       en;
      logic [7:0] acc;
      logic       wr;
      logic       pend;
      logic       bad;
      logic       tgl;
      logic       commit;
      logic       discard;
   } tsa_link_t;

   // One byte through the CRC shift register, MSB first
   function automatic logic [7:0] tsa_crc8(input logic [7:0] c, input logic [7:0] d,
                                           input logic [7:0] p);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ p) : (r << 1);
      end
      return r;
   endfunction : tsa_crc8

endpackage : tsa_pkg

// ==== hdl/tsa_crc_link.sv ====
// Purpose: CRC accumulator and write-commit decision on the link clock
// Assumes: Framer marks start, stop and each byte with its kind
// Notes:   Reset and CRC enable arrive from the core clock via synchronisers
`timescale 1ns/10ps
module tsa_crc_link #(
   parameter logic [7:0] POLY = tsa_pkg::CRC_POLY
) (
   // Link side
   input  wire logic               link_clk,
   input  wire tsa_pkg::tsa_lbyte_t lk,
   input  wire logic               lk_start,
   input  wire logic               lk_stop,
   output logic [7:0]              lk_crc_val,
   output logic                    lk_wr_commit,
   output logic                    lk_wr_discard,
   // From and to the core clock
   input  wire logic               srst,
   input  wire logic               crc_en,
   output logic                    crc_err_tgl
);

   tsa_pkg::tsa_link_t q;
   tsa_pkg::tsa_link_t n;

   // -------------------------------------------------
   // Next state
   // -------------------------------------------------
   always_comb begin
      n = q;
      n.commit = 1'b0;
      n.discard = 1'b0;
      n.rs = {q.rs[1:0], srst};
      n.es = {q.es[1:0], crc_en};
      if (q.rs[1] == q.rs[2]) begin
         n.lrst = q.rs[2];
      end
      if (q.es[1] == q.es[2]) begin
         n.en = q.es[2];
      end
      if (lk.vld) begin
         if (lk.kind == tsa_pkg::K_CRC) begin
            n.acc = tsa_pkg::CRC_SEED;
            if (!lk.rd && q.en) begin
               if (lk.data != q.acc) begin
                  n.tgl = ~q.tgl;
                  n.bad = 1'b1;
               end
               n.pend = 1'b0;
            end
         end else begin
            n.acc = tsa_pkg::tsa_crc8(q.acc, lk.data, POLY);
            if (lk.kind == tsa_pkg::K_ADDR) begin
               n.wr = ~lk.data[0];
            end
            if (lk.kind == tsa_pkg::K_DATA && !lk.rd) begin
               n.pend = 1'b1;
            end
         end
      end
      if (lk_start) begin
         n.acc = tsa_pkg::CRC_SEED;
      end
      // With CRC enabled, a write with data bytes but no CRC byte is dropped and raises no error
      if (lk_stop) begin
         if (q.wr) begin
            n.discard = q.en & (q.pend | q.bad);
            n.commit = ~(q.en & (q.pend | q.bad));
         end
         n.wr = 1'b0;
         n.pend = 1'b0;
         n.bad = 1'b0;
      end
      if (q.lrst) begin
         n.en = 1'b0;
         n.acc = tsa_pkg::CRC_SEED;
         n.wr = 1'b0;
         n.pend = 1'b0;
         n.bad = 1'b0;
         n.tgl = 1'b0;
         n.commit = 1'b0;
         n.discard = 1'b0;
      end
   end

   // Synchronisers ride in the state; reset acts through the next state
   always_ff @(posedge link_clk) begin
      q <= n;
   end

   assign lk_crc_val    = q.acc;
   assign lk_wr_commit  = q.commit;
   assign lk_wr_discard = q.discard;
   assign crc_err_tgl   = q.tgl;

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   chk_crc_seed: assert property (@(posedge link_clk) disable iff (q.lrst)
      lk_start |=> (q.acc == tsa_pkg::CRC_SEED))
      else $error("CRC not reseeded at start");

endmodule : tsa_crc_link

// ==== hdl/tsa_temp_ctrl.sv ====
// Purpose: Conversion sequencer, limit and slew alerts, CRC link glue
// Assumes: Converter front end presents a signed sample on adc_sample
// Notes:   Configuration and limit registers live outside this block
`timescale 1ns/10ps
module tsa_temp_ctrl #(
   parameter int         CONV_CYC = tsa_pkg::CONV_CYC,
   parameter logic [7:0] POLY     = tsa_pkg::CRC_POLY
) (
   // Core clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // Configuration
   input  wire logic                mode_wr,
   input  wire logic                mode_wr_val,
   input  wire logic                os_wr,
   input  wire logic                avg_en,
   input  wire logic [1:0]          period_sel,
   input  wire logic                crc_en,
   input  wire tsa_pkg::tsa_lim_t   lim,
   input  wire logic                stat_rd,
   // Converter front end
   input  wire logic [15:0]         adc_sample,
   // State shown to the register file
   output logic                     mode_shut_r,
   output logic                     os_bit_r,
   output logic                     busy_r,
   output logic [15:0]              result_r,
   output tsa_pkg::tsa_alert_t      alert_r,
   // Link side
   input  wire logic                link_clk,
   input  wire tsa_pkg::tsa_lbyte_t lk,
   input  wire logic                lk_start,
   input  wire logic                lk_stop,
   output logic [7:0]               lk_crc_val,
   output logic                     lk_wr_commit,
   output logic                     lk_wr_discard
);

   tsa_pkg::tsa_core_t q;
   tsa_pkg::tsa_core_t n;
   logic               crc_err_tgl;
   logic               fin;
   logic               crc_evt;
   logic [15:0]        newv;
   logic [18:0]        sum;

   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   // Sign extension keeps limit minus hysteresis from wrapping
   function automatic logic signed [17:0] ext(input logic [15:0] a);
      return {{2{a[15]}}, a};
   endfunction : ext

   function automatic logic signed [17:0] uext(input logic [15:0] a);
      return {2'b00, a};
   endfunction : uext

   function automatic logic [31:0] per_cyc(input logic [1:0] s);
      return 32'(CONV_CYC) << (32'(s) + 32'(tsa_pkg::PER_SHIFT));
   endfunction : per_cyc

   // -------------------------------------------------
   // CRC on the link clock
   // -------------------------------------------------
   tsa_crc_link #(
      .POLY (POLY)
   ) u_crc (
      .link_clk      (link_clk),
      .lk            (lk),
      .lk_start      (lk_start),
      .lk_stop       (lk_stop),
      .lk_crc_val    (lk_crc_val),
      .lk_wr_commit  (lk_wr_commit),
      .lk_wr_discard (lk_wr_discard),
      .srst          (srst),
      .crc_en        (crc_en),
      .crc_err_tgl   (crc_err_tgl)
   );

   // -------------------------------------------------
   // Next state
   // -------------------------------------------------
   always_comb begin
      n = q;
      fin = 1'b0;
      // Error toggle counts once second and third stages agree
      n.tg = {q.tg[1:0], crc_err_tgl};
      crc_evt = (q.tg[1] == q.tg[2]) && (q.tg[2] != q.tg_seen);
      if (q.tg[1] == q.tg[2]) begin
         n.tg_seen = q.tg[2];
      end
      sum = q.acc + {{3{adc_sample[15]}}, adc_sample};
      newv = avg_en ? sum[18:3] : sum[15:0];

      // Clears first, so that a set in the same cycle wins
      if (stat_rd || os_wr) begin
         n.al.hi_flag = 1'b0;
         n.al.lo_flag = 1'b0;
         n.al.slew_flag = 1'b0;
         n.al.crc_flag = 1'b0;
         n.al.rdy_flag = 1'b0;
      end
      if (crc_evt) begin
         n.al.crc_flag = 1'b1;
      end

      unique case (q.st)
         tsa_pkg::ST_IDLE: begin
            n.per = q.per;
         end
         tsa_pkg::ST_CONV: begin
            n.per = q.per + 32'h0000_0001;
            n.cnt = q.cnt + 32'h0000_0001;
            if (q.cnt == 32'(CONV_CYC - 1)) begin
               n.cnt = '0;
               n.acc = sum;
               n.nsmp = q.nsmp + 3'h1;
               if (!avg_en || q.nsmp == 3'h7) begin
                  fin = 1'b1;
                  n.acc = '0;
                  n.nsmp = '0;
                  n.st = q.os_run ? tsa_pkg::ST_IDLE : tsa_pkg::ST_STBY;
               end
            end
         end
         tsa_pkg::ST_STBY: begin
            n.per = q.per + 32'h0000_0001;
            if (q.per >= per_cyc(period_sel) - 32'h0000_0001) begin
               n.st = tsa_pkg::ST_CONV;
               n.per = '0;
               n.cnt = '0;
            end
         end
      endcase

      // Finished result: limits, slew, ready flag
      if (fin) begin
         n.res = newv;
         n.al.rdy_flag = 1'b1;
         if (ext(newv) > ext(lim.hi_lim)) begin
            n.al.hi_live = 1'b1;
            n.al.hi_flag = 1'b1;
         end else if (q.al.hi_live && ext(newv) < ext(lim.hi_lim) - uext(lim.hi_hyst)) begin
            n.al.hi_live = 1'b0;
            n.al.hi_flag = 1'b1;
         end
         if (ext(newv) < ext(lim.lo_lim)) begin
            n.al.lo_live = 1'b1;
            n.al.lo_flag = 1'b1;
         end else if (q.al.lo_live && ext(newv) > ext(lim.lo_lim) + uext(lim.lo_hyst)) begin
            n.al.lo_live = 1'b0;
            n.al.lo_flag = 1'b1;
         end
         // Slew compares only two continuous results in a row
         if (!q.os_run && !q.mode_shut && q.prev_ok) begin
            if (ext(newv) - ext(q.prev) > uext(lim.slew_lim)) begin
               n.al.slew_live = 1'b1;
               n.al.slew_flag = 1'b1;
            end else begin
               n.al.slew_live = 1'b0;
            end
         end
         n.prev = newv;
         n.prev_ok = ~q.os_run;
         if (q.os_run) begin
            n.os_run = 1'b0;
            n.os_bit = 1'b0;
            n.mode_shut = 1'b1;
         end
      end

      // Mode writes; alerts are left as they stand
      if (mode_wr) begin
         n.mode_shut = mode_wr_val;
         if (mode_wr_val) begin
            n.st = tsa_pkg::ST_IDLE;
            n.cnt = '0;
            n.acc = '0;
            n.nsmp = '0;
            n.os_run = 1'b0;
            n.os_bit = 1'b0;
            n.prev_ok = 1'b0;
         end else if (q.mode_shut && !q.os_run) begin
            n.st = tsa_pkg::ST_CONV;
            n.per = '0;
            n.cnt = '0;
         end
      end

      // One-shot has the last word: abort and start over
      if (os_wr) begin
         n.os_bit = 1'b1;
         n.os_run = 1'b1;
         n.st = tsa_pkg::ST_CONV;
         n.cnt = '0;
         n.acc = '0;
         n.nsmp = '0;
         n.per = '0;
         n.prev_ok = 1'b0;
      end
   end

   // -------------------------------------------------
   // State register
   // -------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '{st: tsa_pkg::ST_CONV, mode_shut: tsa_pkg::MODE_RST, al: '0, default: '0};
      end else begin
         q <= n;
      end
   end

   assign mode_shut_r = q.mode_shut;
   assign os_bit_r    = q.os_bit;
   assign busy_r      = (q.st == tsa_pkg::ST_CONV);
   assign result_r    = q.res;
   assign alert_r     = q.al;

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_os_end_shut: assert property ($fell(q.os_bit) && !$past(mode_wr) |-> q.mode_shut
      && q.st == tsa_pkg::ST_IDLE)
      else $error("One-shot end did not enter shutdown");

   chk_flag_read_clear: assert property ($fell(q.al.hi_flag) |-> $past(stat_rd || os_wr))
      else $error("High flag cleared without a status read");

   chk_live_across_read: assert property (stat_rd && !fin && !os_wr |=> $stable(q.al.hi_live))
      else $error("Live bit moved on a status read");

   chk_high_set: assert property (fin && ext(newv) > ext(lim.hi_lim) |=> q.al.hi_live
      && q.al.hi_flag)
      else $error("High limit crossing not recorded");

   chk_result_hold: assert property (!fin |=> $stable(q.res))
      else $error("Result changed without a finished conversion");

   chk_shut_abort: assert property (mode_wr && mode_wr_val && !os_wr |=> !busy_r[*2])
      else $error("Conversion kept running in shutdown");

   chk_crc_flag_set: assert property (crc_evt |=> q.al.crc_flag)
      else $error("CRC error not flagged");

   chk_slew_quiet: assert property (fin && q.os_run |=> !$rose(q.al.slew_flag))
      else $error("Slew alert raised outside continuous mode");

   chk_ready_set: assert property (fin |=> q.al.rdy_flag && q.res == $past(newv))
      else $error("Result or ready flag not updated");

   // -------------------------------------------------
   // Further checks on limits, slew and modes
   // -------------------------------------------------
   // Low side mirrors the high side
   chk_low_set: assert property (fin && ext(newv) < ext(lim.lo_lim) |=> q.al.lo_live
      && q.al.lo_flag)
      else $error("Low limit crossing not recorded");

   // Falling back through the hysteresis band flags again
   chk_high_clear: assert property (fin && q.al.hi_live
      && ext(newv) < ext(lim.hi_lim) - uext(lim.hi_hyst)
      |=> !q.al.hi_live && q.al.hi_flag)
      else $error("High live bit not released below hysteresis");

   // Same band on the low side, rising out of it
   chk_low_clear: assert property (fin && q.al.lo_live
      && ext(newv) > ext(lim.lo_lim) + uext(lim.lo_hyst)
      |=> !q.al.lo_live && q.al.lo_flag)
      else $error("Low live bit not released above hysteresis");

   // Seventeen bits hold any difference of two results
   chk_slew_set: assert property (fin && !q.os_run && !q.mode_shut && q.prev_ok
      && $signed({newv[15], newv}) - $signed({q.prev[15], q.prev}) > $signed({1'b0, lim.slew_lim})
      |=> q.al.slew_live && q.al.slew_flag)
      else $error("Slew rise not flagged");

   // No new slew alert while shut down
   chk_slew_shut: assert property (q.mode_shut |=> !$rose(q.al.slew_live))
      else $error("Slew alert raised in shutdown");

   // A one-shot write restarts from an empty counter
   chk_os_start: assert property (os_wr |=> busy_r && q.os_bit && q.os_run
      && q.cnt == '0)
      else $error("One-shot did not restart the conversion");

   // Mode writes leave every alert bit alone
   chk_mode_alerts: assert property (mode_wr && !fin && !stat_rd && !os_wr && !crc_evt
      |=> q.al == $past(q.al))
      else $error("Mode write changed the alert bits");

   // Shutdown without a one-shot means no conversion
   chk_shut_still: assert property (q.mode_shut && !q.os_run |-> !busy_r)
      else $error("Converting while shut down");

   // The conversion counter never runs past its end
   chk_conv_len: assert property (busy_r |-> q.cnt < 32'(CONV_CYC))
      else $error("Conversion ran longer than its length");

   // Standby belongs to continuous mode only
   chk_stby_cont: assert property (q.st == tsa_pkg::ST_STBY |-> !q.mode_shut && !q.os_run)
      else $error("Standby outside continuous mode");

   // Ready rises only with a finished conversion
   chk_rdy_only_fin: assert property (!fin |=> !$rose(q.al.rdy_flag))
      else $error("Ready flag raised without a result");

   // CRC flag rises only on a link mismatch
   chk_crc_flag_only: assert property (!crc_evt |=> !$rose(q.al.crc_flag))
      else $error("CRC flag raised without a mismatch");

   cov_os_done: cover property ($fell(q.os_bit));
   cov_high_rise: cover property ($rose(q.al.hi_live));
   cov_slew_rise: cover property ($rose(q.al.slew_flag));
   cov_crc_err: cover property (crc_evt);
   cov_low_rise: cover property ($rose(q.al.lo_live));

endmodule : tsa_temp_ctrl

// ==== verif/tsa_bus_model.sv ====
// Purpose: Bus controller model that frames link bytes for the CRC logic
// Assumes: Bytes are already deserialised; one byte per link clock
// Notes:   The bench calls frame() by hierarchical name
`timescale 1ns/10ps
module tsa_bus_model #(
   parameter logic [7:0] POLY = tsa_pkg::CRC_POLY
) (
   // Link side
   input  wire logic           link_clk,
   input  wire logic [7:0]     lk_crc_val,
   output tsa_pkg::tsa_lbyte_t lk,
   output logic                lk_start,
   output logic                lk_stop
);
   logic [7:0] crc;  // Check value the controller expects so far
   logic [7:0] got;  // Device check value seen just after the last byte

   // Own bitwise update, MSB first, kept apart from the core's code
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = {r[6:0], 1'b0} ^ (r[7] ? POLY : 8'h00);
      end
      return r;
   endfunction : crc_step

   initial begin
      lk       = '0;
      lk_start = 1'b0;
      lk_stop  = 1'b0;
      crc      = 8'hff;
      got      = 8'h00;
   end

   // One byte per link clock; a check byte reseeds the value
   task automatic put(input tsa_pkg::tsa_kind_t k, input logic rd, input logic [7:0] d);
      @(posedge link_clk);
      lk_start <= 1'b0;
      lk       <= '{vld: 1'b1, kind: k, rd: rd, data: d};
      crc = (k == tsa_pkg::K_CRC) ? 8'hff : crc_step(crc, d);
   endtask : put

   // Whole frame; a wrong check byte only when flip is nonzero
   task automatic frame(input logic rd, input int n, input logic wc, input logic [7:0] flip);
      @(posedge link_clk);
      lk_start <= 1'b1;
      crc = 8'hff;
      put(tsa_pkg::K_ADDR, 1'b0, {7'h4a, rd});
      if (!rd) put(tsa_pkg::K_PTR, 1'b0, 8'h01);
      for (int i = 0; i < n; i++) put(tsa_pkg::K_DATA, rd, 8'h3c + 8'(i));
      if (wc) put(tsa_pkg::K_CRC, 1'b0, crc ^ flip);
      @(posedge link_clk);
      lk.vld  <= 1'b0;
      lk.data <= ~lk.data;  // Released data does not keep its last value
      lk_stop <= 1'b1;
      #1;
      got = lk_crc_val;
      @(posedge link_clk);
      lk_stop <= 1'b0;
   endtask : frame
endmodule : tsa_bus_model

// ==== verif/tsa_temp_ctrl_tb.sv ====
// Purpose: Self-checking bench of the conversion, alert and CRC core
// Assumes: Short conversion count; link clock free running at 30 ns
// Notes:   One-shot rows first, then hand-written cases
`timescale 1ns/10ps
module tsa_temp_ctrl_tb;
   localparam int C = 40;  // Short conversion keeps the run brief
   localparam logic [2:0] OS = 3'b001, MW = 3'b010, RD = 3'b100;
   logic                clk, link_clk, srst, mode_wr_val, avg_en, crc_en;
   logic [2:0]          strb;
   wire logic           stat_rd, mode_wr, os_wr;
   logic [1:0]          period_sel;
   logic [15:0]         adc_sample, result_r;
   tsa_pkg::tsa_lim_t   lim;
   tsa_pkg::tsa_alert_t alert_r;
   tsa_pkg::tsa_lbyte_t lk;
   logic                lk_start, lk_stop, lk_wr_commit, lk_wr_discard, mode_shut_r, os_bit_r, busy_r;
   logic [7:0]          lk_crc_val;
   int                  n_errors, checked, cyc, n, n_com, n_dis, c0, d0;
   typedef struct packed { logic [15:0] smp; logic [3:0] al; } tsa_row_t;
   // Sample, then high live/flag and low live/flag after it
   tsa_row_t rows [8] = '{20'h00000, 20'h0d00c, 20'h0c008, 20'h0b004,
                          20'heb003, 20'hec802, 20'hee001, 20'h3e80c};
   assign {stat_rd, mode_wr, os_wr} = strb;

   tsa_temp_ctrl #(.CONV_CYC(C)) dut (.clk(clk), .srst(srst), .mode_wr(mode_wr), .mode_wr_val(mode_wr_val),
      .os_wr(os_wr), .avg_en(avg_en), .period_sel(period_sel), .crc_en(crc_en), .lim(lim), .stat_rd(stat_rd),
      .adc_sample(adc_sample), .mode_shut_r(mode_shut_r), .os_bit_r(os_bit_r), .busy_r(busy_r),
      .result_r(result_r), .alert_r(alert_r), .link_clk(link_clk), .lk(lk), .lk_start(lk_start),
      .lk_stop(lk_stop), .lk_crc_val(lk_crc_val), .lk_wr_commit(lk_wr_commit), .lk_wr_discard(lk_wr_discard));
   tsa_bus_model m (.link_clk(link_clk), .lk_crc_val(lk_crc_val), .lk(lk), .lk_start(lk_start),
      .lk_stop(lk_stop));

   // -------------------------------------------------
   // Clocks, link pulse counters and hang guard
   // -------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end
   always @(posedge link_clk) begin
      n_com += int'(lk_wr_commit);
      n_dis += int'(lk_wr_discard);
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         wrap_up();
      end
   end

   // -------------------------------------------------
   // Tasks
   // -------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic pulse(input logic [2:0] s, input logic v);
      @(posedge clk);
      strb        <= s;
      mode_wr_val <= v;
      @(posedge clk);
      strb <= 3'b000;
   endtask : pulse
   // Cycles until the next fall of busy; the global guard stops a hang
   task automatic wait_done(output int k);
      k = 0;
      #1;
      while (busy_r !== 1'b1) begin
         @(posedge clk);
         #1;
         k++;
      end
      while (busy_r !== 1'b0) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask : wait_done
   task automatic set_smp(input logic [15:0] v);
      @(posedge clk);
      adc_sample <= v;
   endtask : set_smp
   task automatic link_txn(input logic rd, input logic wc, input logic [7:0] flip, input int ec, input int ed);
      c0 = n_com;
      d0 = n_dis;
      m.frame(rd, 2, wc, flip);
      repeat (3) @(posedge link_clk);
      #1;
      check(16'(n_com - c0), 16'(ec));
      check(16'(n_dis - d0), 16'(ed));
   endtask : link_txn
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // -------------------------------------------------
   // Main sequence
   // -------------------------------------------------
   initial begin
      {srst, strb, mode_wr_val, avg_en, period_sel, crc_en, adc_sample} = {1'b1, 24'h0};
      lim = '{hi_lim: 16'h0c80, lo_lim: 16'hec00, hi_hyst: 16'h0100, lo_hyst: 16'h0100, slew_lim: 16'h0100};
      repeat (20) @(posedge clk);  // Longer than 5 so the link side reset clears too
      #1;
      check(16'({mode_shut_r, os_bit_r, alert_r}), 16'h0);
      check(result_r, 16'h0);
      @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         set_smp(rows[i].smp);
         pulse(OS, 1'b0);
         wait_done(n);
         check(result_r, rows[i].smp);
         check(16'(alert_r[7:4]), 16'(rows[i].al));
         check(16'({mode_shut_r, os_bit_r, alert_r.rdy_flag}), 16'h5);
      end
      pulse(RD, 1'b1);
      #1;
      check(16'(alert_r[7:6]), 16'h2);
      $display("test rows done");
      // Retrigger inside a conversion, then averaging on a one-shot
      set_smp(16'h0123);
      pulse(OS, 1'b1);
      repeat (30) @(posedge clk);
      pulse(OS, 1'b1);
      repeat (20) @(posedge clk);
      #1;
      check(16'({busy_r, result_r == 16'h3e80}), 16'h3);
      wait_done(n);
      check(result_r, 16'h0123);
      @(posedge clk);
      avg_en <= 1'b1;
      pulse(OS, 1'b1);
      wait_done(n);
      check(16'(n >= 8 * C - 1 && n <= 8 * C + 2), 16'h1);
      @(posedge clk);
      avg_en <= 1'b0;
      $display("test one-shot done");
      // Continuous pacing for every period code
      pulse(MW, 1'b0);
      wait_done(n);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         period_sel <= 2'(s);
         wait_done(n);
         wait_done(n);
         check(16'(n), 16'(C << (s + 4)));
      end
      @(posedge clk);
      period_sel <= 2'd0;
      pulse(RD, 1'b0);
      set_smp(16'h0224);
      wait_done(n);
      check(16'({alert_r[3:2], alert_r.rdy_flag}), 16'h7);
      set_smp(16'h0324);
      wait_done(n);
      check(16'(alert_r[3:2]), 16'h1);
      $display("test continuous done");
      // Shutdown in mid-conversion, then back to continuous
      while (busy_r !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      set_smp(16'h0555);
      pulse(MW, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      check(16'({mode_shut_r, busy_r, alert_r[3:2]}), 16'h9);
      repeat (2 * C) @(posedge clk);
      #1;
      check(result_r, 16'h0324);
      pulse(RD, 1'b0);
      pulse(MW, 1'b0);
      wait_done(n);
      check(16'(alert_r[3:2]), 16'h0);
      set_smp(16'h0700);
      wait_done(n);
      check(16'(alert_r[3:2]), 16'h3);
      $display("test modes done");
      // Link check values with the check off and on
      link_txn(1'b0, 1'b0, 8'h00, 1, 0);
      @(posedge clk);
      crc_en <= 1'b1;
      repeat (10) @(posedge clk);
      link_txn(1'b0, 1'b1, 8'h00, 1, 0);
      check(16'(m.got), 16'h00ff);
      link_txn(1'b0, 1'b1, 8'h01, 0, 1);
      repeat (10) @(posedge clk);
      #1;
      check(16'(alert_r.crc_flag), 16'h1);
      pulse(RD, 1'b0);
      link_txn(1'b0, 1'b0, 8'h00, 0, 1);
      repeat (10) @(posedge clk);
      #1;
      check(16'(alert_r.crc_flag), 16'h0);
      repeat (2) begin
         m.frame(1'b1, 2, 1'b0, 8'h00);
         check(16'(m.got), 16'(m.crc));
      end
      $display("test link done");
      wrap_up();
   end
endmodule : tsa_temp_ctrl_tb
